// ===== core/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// register byte addresses
`define SAC_ADDR_MODE     16'hFF80
`define SAC_ADDR_CHAN     16'hFF84
`define SAC_ADDR_RESULT   16'hFF88
`define SAC_ADDR_UPPER8   16'hFF8C
`define SAC_ADDR_STATUS   16'hFF90
`define SAC_ADDR_MASK     16'hFF94
`define SAC_ADDR_MODE_BIT 16'hFF98

// converter_mode fields
`define SAC_MODE_RESET    8'h00
`define SAC_MODE_WMASK    8'hB9
`define SAC_RUN_BIT       7
`define SAC_RATE_HI       5
`define SAC_RATE_LO       3
`define SAC_CPWR_BIT      0

// single-bit write register fields
`define SAC_BITW_IDX_HI   2
`define SAC_BITW_VAL      8

// result and status fields
`define SAC_SUSPECT_BIT   15
`define SAC_UPPER_LO      2
`define SAC_DONE_BIT      0

// sample / total lengths in peripheral clocks, per rate code
`define SAC_SMP_000 8'd12
`define SAC_TOT_000 8'd36
`define SAC_SMP_001 8'd24
`define SAC_TOT_001 8'd48
`define SAC_SMP_010 8'd48
`define SAC_TOT_010 8'd72
`define SAC_SMP_011 8'd88
`define SAC_TOT_011 8'd112
`define SAC_SMP_100 8'd24
`define SAC_TOT_100 8'd72
`define SAC_SMP_101 8'd48
`define SAC_TOT_101 8'd96
`define SAC_SMP_110 8'd96
`define SAC_TOT_110 8'd144
`define SAC_SMP_111 8'd176
`define SAC_TOT_111 8'd224

// comparison window is split into this many slots, ten used for bits
`define SAC_BIT_SLOTS     8'd12
`define SAC_NUM_BITS      4'd10
`define SAC_MSB_IDX       4'd9
`define SAC_SAR_INIT      10'h200

// comparator settling
`define SAC_CLK_NS        10
`define SAC_SETTLE_NS     1000
`define SAC_SETTLE_CYC    ((`SAC_SETTLE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)

`endif

// ===== core/sac_pkg.sv
package sac_pkg;

  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_SAMPLE  = 2'b01,
    PH_COMPARE = 2'b11
  } sac_phase_e;

  typedef logic [2:0] sac_rate_t;
  typedef logic [9:0] sac_code_t;
  typedef logic [7:0] sac_len_t;

endpackage : sac_pkg

// ===== core/sac_seq_if.sv
`timescale 1ns/1ps

interface sac_seq_if;
  logic cycle_start;
  logic bit_tick;
  logic conv_done;

  modport tmr (output cycle_start, output bit_tick, output conv_done);
  modport eng (input cycle_start, input bit_tick);
  modport top (input conv_done);
endinterface : sac_seq_if

// ===== core/sac_rate_timer.sv
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_rate_timer (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // control
  input  wire logic            run_i,
  input  wire sac_pkg::sac_rate_t rate_i,
  // sequencing
  sac_seq_if.tmr               seq,
  output logic                 sampling_o
);
  import sac_pkg::*;

  sac_phase_e phase_ff;
  sac_len_t   cnt_ff;
  sac_len_t   smp_ff;
  sac_len_t   tot_ff;
  sac_len_t   step_ff;
  sac_len_t   sub_ff;
  logic [3:0] bits_ff;
  logic       start_ff;
  logic       tick_ff;
  logic       done_ff;
  logic       sampling_ff;
  logic       last_smp;
  logic       last_tot;
  logic [15:0] lens;

  // returns {sample, total}
  function automatic logic [15:0] rate_lengths(input sac_rate_t r);
    unique case (r)
      3'b000: rate_lengths = {`SAC_SMP_000, `SAC_TOT_000}; // [R03]
      3'b100: rate_lengths = {`SAC_SMP_100, `SAC_TOT_100}; // [R03]
      3'b110: rate_lengths = {`SAC_SMP_110, `SAC_TOT_110}; // [R04]
      3'b101: rate_lengths = {`SAC_SMP_101, `SAC_TOT_101}; // [R04]
      3'b010: rate_lengths = {`SAC_SMP_010, `SAC_TOT_010}; // [R04]
      3'b001: rate_lengths = {`SAC_SMP_001, `SAC_TOT_001}; // [R04]
      3'b111: rate_lengths = {`SAC_SMP_111, `SAC_TOT_111}; // [R05]
      3'b011: rate_lengths = {`SAC_SMP_011, `SAC_TOT_011}; // [R05]
    endcase
  endfunction : rate_lengths

  assign lens     = rate_lengths(rate_i);
  assign last_smp = (cnt_ff == sac_len_t'(smp_ff - 8'd1));
  assign last_tot = (cnt_ff == sac_len_t'(tot_ff - 8'd1));

  // phase and cycle counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_ff <= PH_IDLE;
      cnt_ff   <= 8'h00;
    end else if (!run_i) begin
      phase_ff <= PH_IDLE;
      cnt_ff   <= 8'h00;
    end else begin
      unique case (phase_ff)
        PH_IDLE: begin
          phase_ff <= PH_SAMPLE;
          cnt_ff   <= 8'h00;
        end
        PH_SAMPLE: begin
          cnt_ff <= sac_len_t'(cnt_ff + 8'd1); // [R19]
          if (last_smp) begin
            phase_ff <= PH_COMPARE;
          end
        end
        PH_COMPARE: begin
          if (last_tot) begin
            phase_ff <= PH_SAMPLE; // [R16]
            cnt_ff   <= 8'h00;
          end else begin
            cnt_ff <= sac_len_t'(cnt_ff + 8'd1);
          end
        end
        default: begin
          phase_ff <= PH_IDLE;
          cnt_ff   <= 8'h00;
        end
      endcase
    end
  end

  // rate latched once per start
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp_ff  <= `SAC_SMP_000;
      tot_ff  <= `SAC_TOT_000;
      step_ff <= 8'h01;
    end else if (run_i && phase_ff == PH_IDLE) begin
      smp_ff  <= lens[15:8]; // [R19]
      tot_ff  <= lens[7:0];
      step_ff <= sac_len_t'((lens[7:0] - lens[15:8]) / `SAC_BIT_SLOTS);
    end
  end

  // bit slot pacing inside the comparison window
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sub_ff  <= 8'h00;
      bits_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else if (!run_i || phase_ff != PH_COMPARE) begin
      sub_ff  <= 8'h00;
      bits_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else if (sub_ff == sac_len_t'(step_ff - 8'd1)) begin
      sub_ff  <= 8'h00;
      tick_ff <= (bits_ff < `SAC_NUM_BITS);
      if (bits_ff < `SAC_NUM_BITS) begin
        bits_ff <= 4'(bits_ff + 4'h1);
      end
    end else begin
      sub_ff  <= sac_len_t'(sub_ff + 8'd1);
      tick_ff <= 1'b0;
    end
  end

  // event pulses and sample-hold level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_ff    <= 1'b0;
      done_ff     <= 1'b0;
      sampling_ff <= 1'b0;
    end else begin
      start_ff    <= run_i && (phase_ff == PH_IDLE || (phase_ff == PH_COMPARE && last_tot));
      done_ff     <= run_i && phase_ff == PH_COMPARE && last_tot;
      sampling_ff <= run_i && (phase_ff == PH_IDLE || (phase_ff == PH_SAMPLE && !last_smp)
                     || (phase_ff == PH_COMPARE && last_tot));
    end
  end

  assign seq.cycle_start = start_ff;
  assign seq.bit_tick    = tick_ff;
  assign seq.conv_done   = done_ff;
  assign sampling_o      = sampling_ff;

endmodule : sac_rate_timer

// ===== core/sac_sar_engine.sv
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_sar_engine (
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      nrst_i,
  // sequencing
  sac_seq_if.eng         seq,
  // comparator
  input  wire logic      comp_i,
  output sac_pkg::sac_code_t code_o
);
  import sac_pkg::*;

  sac_code_t  sar_ff;
  logic [3:0] idx_ff;

  // trial bit set, decided, next lower bit set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sar_ff <= 10'h000;
      idx_ff <= `SAC_MSB_IDX;
    end else if (seq.cycle_start) begin
      sar_ff <= `SAC_SAR_INIT; // [R17]
      idx_ff <= `SAC_MSB_IDX;
    end else if (seq.bit_tick) begin
      sar_ff[idx_ff] <= comp_i; // [R17]
      if (idx_ff != 4'h0) begin
        sar_ff[4'(idx_ff - 4'h1)] <= 1'b1;
        idx_ff <= 4'(idx_ff - 4'h1);
      end
    end
  end

  assign code_o = sar_ff;

endmodule : sac_sar_engine

// ===== core/sac_top.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "sac_map.svh"

//Contract
// R01 - reset clears converter_mode to zero: stopped, comparator off, rate 000.
// R02 - mode bit 7 stops conversion at 0 and starts it at 1.
// R03 - rate 000 samples 12 of 36 clocks; 100 samples 24 of 72.
// R04 - 110: 96/144, 101: 48/96, 010: 48/72, 001: 24/48 clocks.
// R05 - rate 111 samples 176 of 224 clocks; 011 samples 88 of 112.
// R06 - software picks a rate meeting supply limits, total under 100 us.
// R07 - mode bit 0 powers the comparator off at 0, on at 1.
// R08 - run starts even with comparator off; first result is not trustworthy.
// R09 - software waits 1 us after comparator on before setting run.
// R10 - run/enable give stopped, comparator-only waiting, or converting states.
// R11 - after changing other mode bits, software waits two cycles before run.
// R12 - software changes rate bits only while run is 0.
// R13 - software writes zero to mode bits 6, 2 and 1.
// R14 - mode register takes single-bit writes and full byte writes.
// R15 - software allows for clock error up to five percent.
// R16 - conversions repeat back to back until run is cleared.
// R17 - bits decided from 9 to 0; result copied to full and upper8.
// R18 - two-bit channel select, reset to zero, picks one of four inputs.
// R19 - phases timed by a clock counter loaded from rate latched at start.
module sac_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog front end
  input  wire logic        comp_i,
  output logic             sample_hold_o,
  output logic             comp_power_o,
  output logic      [1:0]  chan_sel_o,
  output sac_pkg::sac_code_t dac_code_o,
  // interrupt
  output logic             irq_o
);
  import sac_pkg::*;

  localparam logic [2:0] SEL_MODE = 3'd0;
  localparam logic [2:0] SEL_CHAN = 3'd1;
  localparam logic [2:0] SEL_RES  = 3'd2;
  localparam logic [2:0] SEL_UP8  = 3'd3;
  localparam logic [2:0] SEL_STAT = 3'd4;
  localparam logic [2:0] SEL_MASK = 3'd5;
  localparam logic [2:0] SEL_BITW = 3'd6;
  localparam logic [2:0] SEL_NONE = 3'd7;
  localparam logic [7:0] SETTLE   = 8'(`SAC_SETTLE_CYC);

  logic [7:0]  mode_ff;
  logic [1:0]  chan_ff;
  sac_code_t   result_ff;
  logic        suspect_ff;
  logic        first_ff;
  logic        status_ff;
  logic        mask_ff;
  logic        irq_ff;
  logic        cpwr_ff;
  logic        run_prev_ff;
  logic [7:0]  settle_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  nxt_mode;
  logic [7:0]  bit_onehot;
  logic [2:0]  sel;
  logic        setup;
  logic        wr;
  logic        rd;
  logic        run;
  sac_code_t   code;

  sac_seq_if seq ();

  function automatic logic [2:0] reg_sel(input logic [15:0] a);
    unique case (a)
      `SAC_ADDR_MODE:     reg_sel = SEL_MODE;
      `SAC_ADDR_CHAN:     reg_sel = SEL_CHAN;
      `SAC_ADDR_RESULT:   reg_sel = SEL_RES;
      `SAC_ADDR_UPPER8:   reg_sel = SEL_UP8;
      `SAC_ADDR_STATUS:   reg_sel = SEL_STAT;
      `SAC_ADDR_MASK:     reg_sel = SEL_MASK;
      `SAC_ADDR_MODE_BIT: reg_sel = SEL_BITW;
      default:            reg_sel = SEL_NONE;
    endcase
  endfunction : reg_sel

  assign sel   = reg_sel(paddr_i);
  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pready_ff && pwrite_i && sel != SEL_NONE;
  assign rd    = psel_i && penable_i && pready_ff && !pwrite_i;
  assign run   = mode_ff[`SAC_RUN_BIT];
  assign bit_onehot = 8'(8'h01 << pwdata_i[`SAC_BITW_IDX_HI:0]);

  // byte write replaces all live bits; bit write touches one
  always_comb begin
    nxt_mode = mode_ff;
    if (sel == SEL_MODE) begin
      nxt_mode = pwdata_i[7:0] & `SAC_MODE_WMASK; // [R14]
    end else if (pwdata_i[`SAC_BITW_VAL]) begin
      nxt_mode = (mode_ff | bit_onehot) & `SAC_MODE_WMASK; // [R14]
    end else begin
      nxt_mode = mode_ff & ~bit_onehot;
    end
  end

  // converter_mode
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_ff <= `SAC_MODE_RESET; // [R01]
    end else if (wr && (sel == SEL_MODE || sel == SEL_BITW)) begin
      mode_ff <= nxt_mode; // [R02] [R07]
    end
  end

  // input_channel_select
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_ff <= 2'h0; // [R18]
    end else if (wr && sel == SEL_CHAN) begin
      chan_ff <= pwdata_i[1:0]; // [R18]
    end
  end

  // comparator powered while enabled or converting
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpwr_ff <= 1'b0;
    end else begin
      cpwr_ff <= mode_ff[`SAC_CPWR_BIT] || run; // [R10] [R07]
    end
  end

  // comparator settle tracking flags a first result taken too early
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_ff <= 8'h00;
    end else if (!cpwr_ff) begin
      settle_ff <= 8'h00;
    end else if (settle_ff != SETTLE) begin
      settle_ff <= 8'(settle_ff + 8'h01);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_prev_ff <= 1'b0;
      first_ff    <= 1'b0;
    end else begin
      run_prev_ff <= run;
      if (run && !run_prev_ff) begin
        first_ff <= (settle_ff != SETTLE); // [R08]
      end else if (seq.conv_done) begin
        first_ff <= 1'b0;
      end
    end
  end

  // result_full / result_upper8 capture
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_ff  <= 10'h000;
      suspect_ff <= 1'b0;
    end else if (seq.conv_done) begin
      result_ff  <= code; // [R17]
      suspect_ff <= first_ff; // [R08]
    end
  end

  // sticky done flag, read clears, a new event wins
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_ff <= 1'b0;
    end else if (seq.conv_done) begin
      status_ff <= 1'b1; // [R17]
    end else if (rd && sel == SEL_STAT) begin
      status_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_ff <= 1'b0;
    end else if (wr && sel == SEL_MASK) begin
      mask_ff <= pwdata_i[`SAC_DONE_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= status_ff && mask_ff;
    end
  end

  // apb: one wait-free access phase, data prepared in setup
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && sel == SEL_NONE;
      if (setup && !pwrite_i) begin
        prdata_ff <= 32'h0000_0000;
        unique case (sel)
          SEL_MODE: prdata_ff[7:0] <= mode_ff;
          SEL_CHAN: prdata_ff[1:0] <= chan_ff;
          SEL_RES: begin
            prdata_ff[9:0]              <= result_ff;
            prdata_ff[`SAC_SUSPECT_BIT] <= suspect_ff;
          end
          SEL_UP8:  prdata_ff[7:0] <= result_ff[9:`SAC_UPPER_LO]; // [R17]
          SEL_STAT: prdata_ff[`SAC_DONE_BIT] <= status_ff;
          SEL_MASK: prdata_ff[`SAC_DONE_BIT] <= mask_ff;
          SEL_BITW: prdata_ff <= 32'h0000_0000;
          SEL_NONE: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  sac_rate_timer u_timer (
    .clk_i      (mclk_i),
    .nrst_i     (nrst_i),
    .run_i      (run), // [R02] [R10]
    .rate_i     (mode_ff[`SAC_RATE_HI:`SAC_RATE_LO]),
    .seq        (seq.tmr),
    .sampling_o (sample_hold_o)
  );

  sac_sar_engine u_engine (
    .clk_i  (mclk_i),
    .nrst_i (nrst_i),
    .seq    (seq.eng),
    .comp_i (comp_i),
    .code_o (code)
  );

  assign prdata_o     = prdata_ff;
  assign pready_o     = pready_ff;
  assign pslverr_o    = pslverr_ff;
  assign comp_power_o = cpwr_ff;
  assign chan_sel_o   = chan_ff;
  assign dac_code_o   = code;
  assign irq_o        = irq_ff;

endmodule : sac_top

// ===== tb/sac_checker.sv
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_checker (
  // clock and reset
  input wire logic               mclk_i,
  input wire logic               nrst_i,
  // apb
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire logic [15:0]        paddr_i,
  input wire logic [31:0]        pwdata_i,
  input wire logic [31:0]        prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  // analog front end and interrupt
  input wire logic               comp_i,
  input wire logic               sample_hold_o,
  input wire logic               comp_power_o,
  input wire logic [1:0]         chan_sel_o,
  input wire sac_pkg::sac_code_t dac_code_o,
  input wire logic               irq_o
);
  import sac_pkg::*;
  // sample and total length per rate code
  localparam logic [15:0] lens_c [8] = '{16'h0C24, 16'h1830, 16'h3048, 16'h5870,
                                         16'h1848, 16'h3060, 16'h6090, 16'hB0E0};
  logic       wr, chan_wr, mapped;
  logic       run_ff, msk_ff, seen_ff;
  sac_rate_t  rate_ff;
  logic [7:0] smp_ff, per_ff;

  assign wr      = psel_i & penable_i & pready_o & pwrite_i;
  assign chan_wr = wr && paddr_i == `SAC_ADDR_CHAN;
  assign mapped  = paddr_i >= 16'hFF80 && paddr_i <= 16'hFF98 && paddr_i[1:0] == 2'h0;

  // software view of the mode register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_ff  <= 1'b0;
      rate_ff <= 3'h0;
    end else if (wr && paddr_i == `SAC_ADDR_MODE) begin
      run_ff  <= pwdata_i[7];
      rate_ff <= pwdata_i[5:3];
    end else if (wr && paddr_i == `SAC_ADDR_MODE_BIT && pwdata_i[2:0] == 3'h7) begin
      run_ff  <= pwdata_i[8];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      msk_ff <= 1'b0;
    end else if (wr && paddr_i == `SAC_ADDR_MASK) begin
      msk_ff <= pwdata_i[0];
    end
  end

  // sample length and cycle period counters
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp_ff  <= 8'h00;
      per_ff  <= 8'h00;
      seen_ff <= 1'b0;
    end else begin
      smp_ff  <= sample_hold_o ? smp_ff + 8'h01 : 8'h00;
      per_ff  <= (sample_hold_o && smp_ff == 8'h00) ? 8'h01 : per_ff + 8'h01;
      seen_ff <= run_ff & (seen_ff | sample_hold_o);
    end
  end

  a_pready_next: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    psel_i && !penable_i |=> pready_o) else $error("no ready in access cycle");
  a_err_unmapped: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    psel_i && !penable_i |=> pslverr_o == !mapped) else $error("bad error response");
  a_cpwr_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    wr && paddr_i == `SAC_ADDR_MODE |-> ##2
    comp_power_o == ($past(pwdata_i[0], 2) | $past(pwdata_i[7], 2)))
    else $error("comparator power wrong");
  a_sample_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(sample_hold_o) && run_ff |-> smp_ff == lens_c[rate_ff][15:8])
    else $error("sample length wrong");
  a_cycle_period: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(sample_hold_o) && seen_ff |-> per_ff == lens_c[rate_ff][7:0])
    else $error("conversion period wrong");
  a_stop_idle: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !run_ff |=> !sample_hold_o) else $error("sampling while stopped");
  a_start_sample: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(run_ff) |-> ##[1:4] sample_hold_o) else $error("no sampling after start");
  a_dac_msb: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(sample_hold_o) && run_ff |-> dac_code_o == 10'h200)
    else $error("compare does not begin at midscale");
  a_irq_mask: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    irq_o |-> $past(msk_ff)) else $error("interrupt while masked");
  a_chan_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !chan_wr && !$past(chan_wr) |=> $stable(chan_sel_o)) else $error("channel moved");
endmodule : sac_checker

bind sac_top sac_checker u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .comp_i(comp_i),
  .sample_hold_o(sample_hold_o), .comp_power_o(comp_power_o), .chan_sel_o(chan_sel_o),
  .dac_code_o(dac_code_o), .irq_o(irq_o));

// ===== tb/sac_afe_model.sv
`timescale 1ns/1ps

module sac_afe_model (
  // clock
  input  wire logic        mclk_i,
  // from converter, plus input voltages from the testbench
  input  wire logic        sample_i,
  input  wire logic        power_i,
  input  wire logic [1:0]  chan_i,
  input  wire logic [9:0]  tap_i,
  input  wire logic [39:0] vin_i,
  // to converter
  output logic             comp_o
);
  logic [9:0] held_ff = 10'h000;
  logic       tog_ff = 1'b0;

  always_ff @(posedge mclk_i) begin
    tog_ff <= !tog_ff;
    if (sample_i) begin
      held_ff <= vin_i[10*chan_i +: 10];
    end
  end

  // an unpowered comparator gives no usable decision
  assign comp_o = power_i ? (held_ff >= tap_i) : tog_ff;
endmodule : sac_afe_model

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "sac_map.svh"

module tb;
  import sac_pkg::*;
  logic        mclk_i, nrst_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, comp_i, sample_hold_o, comp_power_o, irq_o;
  logic [15:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [1:0]  chan_sel_o, ch;
  sac_code_t   dac_code_o;
  logic [9:0]  vin [4];
  logic [32:0] expq [$];
  integer      n_errors, n_compared, seed, i;

  sac_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .comp_i(comp_i),
    .sample_hold_o(sample_hold_o), .comp_power_o(comp_power_o), .chan_sel_o(chan_sel_o),
    .dac_code_o(dac_code_o), .irq_o(irq_o));
  sac_afe_model u_afe (.mclk_i(mclk_i), .sample_i(sample_hold_o), .power_i(comp_power_o),
    .chan_i(chan_sel_o), .tap_i(dac_code_o), .vin_i({vin[3], vin[2], vin[1], vin[0]}),
    .comp_o(comp_i));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic final_report;
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    integer k;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    expq.push_back(exp);
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k = k + 1;
    end while (pready_o !== 1'b1 && k < 50);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k == 50) begin
      n_errors = n_errors + 1;
      final_report();
    end
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask : rd

  task automatic wait_irq;
    integer k;
    repeat (2) @(posedge mclk_i);
    k = 0;
    while (irq_o !== 1'b1 && k < 1000) begin
      @(posedge mclk_i);
      k = k + 1;
    end
    if (k == 1000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  endtask : wait_irq

  // completed transfers are checked against the oldest note
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && expq.size() > 0) begin
      chk({pslverr_o, pwrite_i ? 32'h0 : prdata_o}, expq.pop_front());
    end
  end

  initial begin
    seed = 32'h219F;
    n_errors = 0;
    n_compared = 0;
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 16'h0000;
    pwdata_i = 32'h0;
    for (i = 0; i < 4; i++) vin[i] = 10'($random(seed));
    ch = 2'($random(seed));
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    chk({31'h0, comp_power_o, sample_hold_o}, 33'h0);
    rd(`SAC_ADDR_MODE, 32'h0);
    rd(`SAC_ADDR_CHAN, 32'h0);
    apb(1'b0, 16'hFF9C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 16'h0000, 32'hFFFFFFFF, {1'b1, 32'h0});
    wr(`SAC_ADDR_CHAN, {30'h0, ch});
    rd(`SAC_ADDR_CHAN, {30'h0, ch});
    wr(`SAC_ADDR_MODE, 32'h47);
    rd(`SAC_ADDR_MODE, 32'h01);
    wr(`SAC_ADDR_MASK, 32'h1);
    repeat (100) @(posedge mclk_i);
    chk({31'h0, comp_power_o, sample_hold_o}, 33'h2);
    // every rate code stays well under 100 us total at this clock, margin included
    for (i = 0; i < 8; i++) begin
      wr(`SAC_ADDR_MODE, {26'h0, 3'(i), 3'b001});
      repeat (2) @(posedge mclk_i);
      wr(`SAC_ADDR_MODE_BIT, 32'h107);
      rd(`SAC_ADDR_MODE, {24'h0, 2'b10, 3'(i), 3'b001});
      wait_irq;
      rd(`SAC_ADDR_RESULT, {22'h0, vin[ch]});
      rd(`SAC_ADDR_UPPER8, {24'h0, vin[ch][9:2]});
      rd(`SAC_ADDR_STATUS, 32'h1);
      wait_irq;
      rd(`SAC_ADDR_STATUS, 32'h1);
      wr(`SAC_ADDR_MODE_BIT, 32'h007);
    end
    rd(`SAC_ADDR_MODE_BIT, 32'h0);
    wr(`SAC_ADDR_MODE, 32'h0);
    repeat (2) @(posedge mclk_i);
    wr(`SAC_ADDR_MODE, 32'h80);
    wait_irq;
    rd(`SAC_ADDR_RESULT, {16'h0, 1'b1, 5'h0, vin[ch]});
    rd(`SAC_ADDR_STATUS, 32'h1);
    wait_irq;
    rd(`SAC_ADDR_RESULT, {22'h0, vin[ch]});
    rd(`SAC_ADDR_STATUS, 32'h1);
    wr(`SAC_ADDR_MASK, 32'h0);
    repeat (100) @(posedge mclk_i);
    chk({32'h0, irq_o}, 33'h0);
    rd(`SAC_ADDR_STATUS, 32'h1);
    wr(`SAC_ADDR_MODE, 32'h0);
    repeat (4) @(posedge mclk_i);
    final_report();
  end
endmodule : tb
